// *** logic/valley_pwm_consts.svh ***
// constants for the valley-switching pwm core
// assumes a 50 MHz system clock; times are kept in their own unit
`ifndef VALLEY_PWM_CONSTS_SVH
`define VALLEY_PWM_CONSTS_SVH
// clock period in ns
`define CLK_NS          20
// missing-valley timeouts and blanking, ns
`define TO_QR_NS        5500
`define TO_SS_NS        40000
`define BLANK_NS        250
`define SHORT_BLANK_NS  100
// soft-start, overload tick and auto-recovery wait, us
`define SS_US           4000
`define OVLD_TICK_US    10000
`define AUTO_WAIT_US    100000
// overload counts to completion
`define OVLD_DONE       4'h8
// highest valley code (fourth valley)
`define VALLEY_MAX      2'h3
// register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_IRQ_STAT    4'h8
`define REG_IRQ_MASK    4'hc
// field positions
`define CTRL_RUN        0
`define IRQ_OVLD        0
`define IRQ_LATCH       1
`define IRQ_BROWN       2
`define IRQ_WSHORT      3
`define IRQ_W           4
// axi responses
`define RESP_OK         2'h0
`define RESP_ERR        2'h2
`endif

// *** logic/valley_pwm_core.sv ***
// valley-switching pwm core of a quasi-resonant flyback controller
// assumes analog comparators on comp, a gate driver on gate_drive_out
// and an axi4-lite master for the registers
//
// Function
// - lock valley, step later, stop at fourth
// - timeout replaces missing valley clock
// - fixed soft-start after every startup
// - temperature variants latch off on fault
// - brown-out stops; restart is full startup
// - brown-out variants latch on over-voltage
// - overload timer up/down, stop at completion
// - latch or auto-recover on overload
// - winding short inside blanking window stops
// - quasi-resonant mode with feedback hysteresis
// - qr setpoint is feedback divided by four
// - foldback freezes setpoint at 17.5 percent
// - foldback period ends at ramp, discharge
// - count valleys on falling zero cross
// - advance valleys, fourth then foldback
// - longer timeout during soft-start
// - overload steps per interval, done at eight
`timescale 1ns/100ps
`include "valley_pwm_consts.svh"
module valley_pwm_core #(
   parameter int SS_CYC   = `SS_US * 1000 / `CLK_NS,        // soft-start
   parameter int TICK_CYC = `OVLD_TICK_US * 1000 / `CLK_NS, // overload step
   parameter int AUTO_CYC = `AUTO_WAIT_US * 1000 / `CLK_NS  // auto restart
) (
   input  wire logic                  sys_clk,        // 50 MHz clock
   input  wire logic                  rst_n,          // async reset
   input  wire valley_pwm_pkg::comp_s comp,           // comparators
   input  wire logic                  variant_bo,     // strap: brown-out
   input  wire logic                  variant_auto,   // strap: auto-rec
   output logic                       gate_drive_out, // gate command
   output logic                       ct_discharge,   // ramp reset pulse
   output valley_pwm_pkg::setpoint_s  setpoint,       // peak setpoint
   output logic                       vcc_latch_pull, // hold supply low
   output logic                       irq,            // level interrupt
   input  wire logic [3:0]            s_axi_awaddr,   // write address
   input  wire logic                  s_axi_awvalid,  // aw valid
   output logic                       s_axi_awready,  // aw ready
   input  wire logic [31:0]           s_axi_wdata,    // write data
   input  wire logic [3:0]            s_axi_wstrb,    // byte enables
   input  wire logic                  s_axi_wvalid,   // w valid
   output logic                       s_axi_wready,   // w ready
   output logic [1:0]                 s_axi_bresp,    // write response
   output logic                       s_axi_bvalid,   // b valid
   input  wire logic                  s_axi_bready,   // b ready
   input  wire logic [3:0]            s_axi_araddr,   // read address
   input  wire logic                  s_axi_arvalid,  // ar valid
   output logic                       s_axi_arready,  // ar ready
   output logic [31:0]                s_axi_rdata,    // read data
   output logic [1:0]                 s_axi_rresp,    // read response
   output logic                       s_axi_rvalid,   // r valid
   input  wire logic                  s_axi_rready    // r ready
);
   import valley_pwm_pkg::*;
   localparam logic [11:0] TO_QR = 12'(`TO_QR_NS / `CLK_NS);
   localparam logic [11:0] TO_SS = 12'(`TO_SS_NS / `CLK_NS);
   localparam logic [4:0]  BLANK = 5'((`BLANK_NS + `CLK_NS - 1) / `CLK_NS);
   localparam logic [4:0]  SBLK  = 5'((`SHORT_BLANK_NS + `CLK_NS - 1) / `CLK_NS);
   localparam int          SS_STEP = SS_CYC / 256 > 0 ? SS_CYC / 256 : 1;

   // ************************************************
   // reset release and input synchronisers
   // ************************************************
   logic        rs1_reg, rst_sync_n;       // reset release chain
   logic [14:0] s1_reg, s2_reg;            // two-stage sync
   logic        zc_d_reg;                  // delayed zero cross
   comp_s       c;                         // synchronised view
   logic        strap_done_reg;            // straps captured
   logic        bo_var_reg, auto_var_reg;  // captured variant

   // release the reset through two flops, assert at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_reg    <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rs1_reg    <= 1'b1;
         rst_sync_n <= rs1_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         zc_d_reg <= 1'b0;
      end else begin
         s1_reg   <= comp;
         s2_reg   <= s1_reg;
         zc_d_reg <= s2_reg[14];
      end
   end
   assign c = comp_s'(s2_reg);

   // straps are sampled once after reset release, never under reset
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         strap_done_reg <= 1'b0;
         bo_var_reg     <= 1'b0;
         auto_var_reg   <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         bo_var_reg     <= variant_bo;
         auto_var_reg   <= variant_auto;
      end
   end

   // ************************************************
   // operating valley and mode selection
   // ************************************************
   logic [1:0] valley_reg;  // 0..3 is first..fourth valley
   logic       fold_reg;    // frequency_foldback_mode

   // hysteretic valley lock: one step per crossing, never past the fourth
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         valley_reg <= 2'h0;
         fold_reg   <= 1'b0;
      end else if (fold_reg) begin
         // leave foldback only above the higher level
         if (c.fbk_up[0]) fold_reg <= 1'b0;
      end else begin
         // lighter load moves to a later valley
         unique case (valley_reg)
            2'h0: if (c.fbk_dn[0]) valley_reg <= 2'h1;
            2'h1: begin
               if (c.fbk_dn[1]) valley_reg <= 2'h2;
               else if (c.fbk_up[3]) valley_reg <= 2'h0;
            end
            2'h2: begin
               if (c.fbk_dn[2]) valley_reg <= `VALLEY_MAX;
               else if (c.fbk_up[2]) valley_reg <= 2'h1;
            end
            2'h3: begin
               if (c.fbk_dn[3]) fold_reg <= 1'b1;
               else if (c.fbk_up[1]) valley_reg <= 2'h2;
            end
         endcase
      end
   end

   // ************************************************
   // protection state
   // ************************************************
   logic        run_reg;           // software run enable
   logic        latch_reg;         // latched off until supply cycle or brown-out end
   logic        bo_reg;            // brown-out stop
   logic        hold_reg;          // auto-recovery wait
   logic [31:0] hold_cnt_reg;      // auto-recovery countdown
   logic [3:0]  ovld_reg;          // overload timer count
   logic [31:0] tick_reg;          // overload step divider
   logic        ovld_ev, wshort_ev, latch_ev, bo_ev; // one-cycle events
   logic        stop_ev;           // overload or winding short trip
   logic        runnable;          // switching allowed
   gate_e       st_reg;            // gate sequencer state
   logic [4:0]  blank_reg;         // on-time blanking counter

   // step the timer once per interval
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tick_reg <= '0;
         ovld_reg <= 4'h0;
      end else begin
         tick_reg <= (tick_reg == 32'(TICK_CYC - 1)) ? '0 : tick_reg + 32'h1;
         if (tick_reg == 32'(TICK_CYC - 1)) begin
            // up while max peak flag, down once clear
            if (c.max_ip && ovld_reg != `OVLD_DONE) ovld_reg <= ovld_reg + 4'h1;
            else if (!c.max_ip && ovld_reg != 4'h0) ovld_reg <= ovld_reg - 4'h1;
         end
      end
   end

   // completion with flag still present stops pulses
   assign ovld_ev   = (ovld_reg == `OVLD_DONE) && c.max_ip && runnable;
   // short comparator honoured after short blank, inside main blank
   assign wshort_ev = (st_reg == ST_ON) && c.winding_short
                      && blank_reg >= SBLK && blank_reg < BLANK;
   assign stop_ev   = ovld_ev || wshort_ev;
   assign latch_ev  = !latch_reg && (c.over_voltage_trip
                      || (!bo_var_reg && c.fault_low));
   assign bo_ev     = bo_var_reg && c.fault_low && !bo_reg;
   assign runnable  = strap_done_reg && run_reg && !latch_reg
                      && !bo_reg && !hold_reg;

   // fault policy; a supply cycle is modelled by rst_n
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         latch_reg    <= 1'b0;
         bo_reg       <= 1'b0;
         hold_reg     <= 1'b0;
         hold_cnt_reg <= '0;
      end else begin
         // low input stops; recovery clears the latch for a clean start
         if (bo_var_reg && c.fault_low) bo_reg <= 1'b1;
         else if (bo_reg) begin
            bo_reg    <= 1'b0;
            latch_reg <= 1'b0;
         end
         if (latch_ev) latch_reg <= 1'b1;
         // latching variants latch, auto variants wait then restart
         if (stop_ev && !auto_var_reg) latch_reg <= 1'b1;
         if (stop_ev && auto_var_reg) begin
            hold_reg     <= 1'b1;
            hold_cnt_reg <= 32'(AUTO_CYC);
         end else if (hold_reg) begin
            hold_cnt_reg <= hold_cnt_reg - 32'h1;
            if (hold_cnt_reg == 32'h1) hold_reg <= 1'b0;
         end
      end
   end

   // ************************************************
   // soft-start
   // ************************************************
   logic [7:0]  ss_lvl_reg;  // current clamp level
   logic [31:0] ss_div_reg;  // step divider
   logic        ss_active;   // soft-start still ramping

   // ramp restarts whenever switching is stopped
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ss_lvl_reg <= 8'h00;
         ss_div_reg <= '0;
      end else if (st_reg == ST_STOP) begin
         ss_lvl_reg <= 8'h00;
         ss_div_reg <= '0;
      end else if (ss_active) begin
         ss_div_reg <= (ss_div_reg == 32'(SS_STEP - 1)) ? '0 : ss_div_reg + 32'h1;
         if (ss_div_reg == 32'(SS_STEP - 1)) ss_lvl_reg <= ss_lvl_reg + 8'h01;
      end
   end
   assign ss_active = ss_lvl_reg != 8'hff;

   // qr setpoint tracks feedback / 4
   // foldback freezes at the minimum fraction
   always_comb begin
      setpoint.fbk_div4 = !fold_reg;
      setpoint.fold_min = fold_reg;
      setpoint.ss_limit = ss_lvl_reg;
   end

   // ************************************************
   // gate sequencer
   // ************************************************
   logic [2:0]  vcnt_reg;   // valleys since turn-off
   logic [11:0] to_reg;     // missing-valley timer
   logic        valley_ev;  // valley or timeout substitute
   logic        zc_fall;    // falling zero cross
   logic        dis_reg;    // discharge pulse

   // falling crossing of zero_cross_sense is a valley
   assign zc_fall   = zc_d_reg && !c.zero_cross_sense;
   // longer timeout while soft-start runs
   // at or past the limit, so a timer already beyond the short limit when
   // soft-start ends still fires instead of wrapping
   assign valley_ev = zc_fall || to_reg >= (ss_active ? TO_SS : TO_QR);

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_reg    <= ST_STOP;
         blank_reg <= 5'h0;
         vcnt_reg  <= 3'h0;
         to_reg    <= 12'h0;
         dis_reg   <= 1'b0;
      end else begin
         dis_reg <= 1'b0;
         if (!runnable || stop_ev || latch_ev || bo_ev) st_reg <= ST_STOP;
         else begin
            unique case (st_reg)
               ST_STOP: begin
                  st_reg    <= ST_ON;
                  blank_reg <= 5'h0;
               end
               ST_ON: begin
                  if (blank_reg != 5'h1f) blank_reg <= blank_reg + 5'h1;
                  if (blank_reg >= BLANK && c.peak_trip) begin
                     st_reg   <= ST_OFF;
                     vcnt_reg <= 3'h0;
                     to_reg   <= 12'h0;
                  end
               end
               ST_OFF: begin
                  to_reg <= valley_ev ? 12'h0 : to_reg + 12'h1;
                  if (valley_ev && vcnt_reg != 3'h7) vcnt_reg <= vcnt_reg + 3'h1;
                  // foldback: ramp end discharges and starts a period
                  if (fold_reg && c.ramp_done) begin
                     dis_reg   <= 1'b1;
                     st_reg    <= ST_ON;
                     blank_reg <= 5'h0;
                  // turn on at the selected valley
                  end else if (!fold_reg && valley_ev
                               && vcnt_reg == {1'b0, valley_reg}) begin
                     st_reg    <= ST_ON;
                     blank_reg <= 5'h0;
                  end
               end
               // unused code: fall back to a safe stop
               default: st_reg <= ST_STOP;
            endcase
         end
      end
   end
   assign gate_drive_out = st_reg == ST_ON;
   assign ct_discharge   = dis_reg;
   assign vcc_latch_pull = latch_reg;

   // ************************************************
   // registers and interrupts over axi4-lite
   // ************************************************
   logic [`IRQ_W-1:0] ista_reg, imask_reg; // sticky status, mask
   logic [`IRQ_W-1:0] ev_vec;              // event vector
   logic              aw_reg, w_reg;       // address/data captured
   logic [3:0]        awa_reg;             // captured address
   logic [31:0]       wd_reg;              // captured data
   logic              wstrb0_reg;          // low lane enabled
   logic              rd_clr;              // status read this cycle

   assign ev_vec = {wshort_ev, bo_ev, latch_ev, ovld_ev};
   assign irq    = |(ista_reg & imask_reg);
   assign s_axi_awready = !aw_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_clr = s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_IRQ_STAT;

   // write side: address and data in either order, then a response
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_reg       <= 1'b0;
         w_reg        <= 1'b0;
         awa_reg      <= 4'h0;
         wd_reg       <= '0;
         wstrb0_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OK;
         run_reg      <= 1'b0;
         imask_reg    <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_reg  <= 1'b1;
            awa_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_reg      <= 1'b1;
            wd_reg     <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (aw_reg && w_reg) begin
            aw_reg       <= 1'b0;
            w_reg        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OK;
            unique case (awa_reg)
               `REG_CTRL: if (wstrb0_reg) run_reg <= wd_reg[`CTRL_RUN];
               `REG_IRQ_MASK: if (wstrb0_reg) imask_reg <= wd_reg[`IRQ_W-1:0];
               `REG_STATUS, `REG_IRQ_STAT: ;
               default: s_axi_bresp <= `RESP_ERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end

   // read side; status read clears, a new event in that cycle survives
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `RESP_OK;
         ista_reg     <= '0;
      end else begin
         ista_reg <= (rd_clr ? '0 : ista_reg) | ev_vec;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OK;
            s_axi_rdata  <= '0;
            unique case (s_axi_araddr)
               `REG_CTRL:     s_axi_rdata <= 32'(run_reg);
               `REG_STATUS:   s_axi_rdata <= {16'h0, ovld_reg, 1'b0, bo_var_reg,
                                 auto_var_reg, hold_reg, bo_reg, latch_reg,
                                 fold_reg, gate_drive_out, valley_reg, st_reg};
               `REG_IRQ_STAT: s_axi_rdata <= 32'(ista_reg);
               `REG_IRQ_MASK: s_axi_rdata <= 32'(imask_reg);
               default:       s_axi_rresp <= `RESP_ERR;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   ovld_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      ovld_ev |=> !gate_drive_out) else $error("gate on after overload trip");
   latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      latch_reg && !bo_reg |=> latch_reg) else $error("latch dropped");
   auto_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      stop_ev && auto_var_reg |=> hold_reg && !gate_drive_out)
      else $error("auto recovery did not hold");
   valley_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      valley_reg == `VALLEY_MAX && !c.fbk_up[1] |=> valley_reg == `VALLEY_MAX)
      else $error("valley left fourth without cause");
   fold_hyst_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      fold_reg && !c.fbk_up[0] |=> fold_reg) else $error("foldback left early");
   turnoff_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      st_reg == ST_ON ##1 st_reg == ST_OFF |-> vcnt_reg == 3'h0)
      else $error("valley count not cleared");
   bo_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bo_reg |-> !gate_drive_out) else $error("switching in brown-out");
   wshort_blank_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      wshort_ev |-> blank_reg < BLANK ##1 !gate_drive_out)
      else $error("winding short outside window");
   ss_ramp_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      $rose(gate_drive_out) && $past(st_reg) == ST_STOP |-> ss_lvl_reg == 8'h00)
      else $error("soft-start not restarted");
   timeout_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      st_reg == ST_OFF |-> to_reg <= TO_SS) else $error("timeout overran");
endmodule

// *** logic/valley_pwm_pkg.sv ***
// types shared by the valley-switching pwm core
// no logic; comparator levels come from the analog front end
package valley_pwm_pkg;
   // comparator levels, all passed through a two-stage synchroniser in the core
   typedef struct packed {
      logic       zero_cross_sense; // aux winding above valley threshold
      logic       peak_trip;        // sense reached the setpoint
      logic       max_ip;           // sense reached peak_limit_level
      logic       winding_short;    // sense reached 1.5x peak limit
      logic       ramp_done;        // timing ramp reached its threshold
      logic       fault_low;        // fault pin below low level
      logic       over_voltage_trip;// fault pin above high level
      logic [3:0] fbk_dn;           // feedback below 1.4/1.2/0.9/0.8
      logic [3:0] fbk_up;           // feedback above 1.4/1.6/1.8/2.0
   } comp_s;
   // peak-current setpoint selection toward the analog side
   typedef struct packed {
      logic       fbk_div4; // setpoint follows feedback_level / 4
      logic       fold_min; // setpoint frozen at 17.5 % of max
      logic [7:0] ss_limit; // soft-start clamp, 8'hff is no clamp
   } setpoint_s;
   typedef enum logic [1:0] {ST_STOP, ST_ON, ST_OFF} gate_e;
endpackage

// *** tb/pwr_stage_model.sv ***
// comparator and power stage model for the pwm core
// assumes gate from the core and zone levels from the bench
`timescale 1ns/100ps
module pwr_stage_model (
   input  wire logic             sys_clk,   // clock
   input  wire logic             gate,      // gate command
   input  wire logic             ring_en,   // ringing visible
   input  wire logic [3:0]       fbk_dn,    // zones, falling
   input  wire logic [3:0]       fbk_up,    // zones, rising
   input  wire logic             max_ip,    // overload level
   output valley_pwm_pkg::comp_s comp       // comparator levels
);
   import valley_pwm_pkg::*;
   logic [5:0] ph_reg;                // cycles since gate edge
   logic       gate_reg;              // gate one cycle back
   // phase restarts at each gate edge
   always_ff @(posedge sys_clk) begin
      gate_reg <= gate;
      ph_reg   <= (gate != gate_reg) ? 6'h0 : ph_reg + 6'h1;
   end
   // ringing falls every 8 cycles; damped ringing stays high
   assign comp = {!gate & (ph_reg[2] | !ring_en), gate & (ph_reg > 6'h10), max_ip,
                  1'b0, !gate & (ph_reg == 6'h0c), 1'b0, 1'b0, fbk_dn, fbk_up};
endmodule

// *** tb/valley_switching_pwm_logic_test.sv ***
// self-checking bench for the valley pwm core over axi4-lite
// assumes the model drives the comparators
`timescale 1ns/100ps
`include "valley_pwm_consts.svh"
module valley_switching_pwm_logic_test;
   import valley_pwm_pkg::*;
   logic sys_clk = 0, rst_n = 0, variant_bo = 0, variant_auto = 0, ring_en = 1;
   logic gate_drive_out, ct_discharge, vcc_latch_pull, irq, max_ip = 0;
   logic [3:0] fbk_dn = 0, fbk_up = 4'hf, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, br;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   comp_s comp;
   setpoint_s setpoint;
   int fail_count = 0, comparisons = 0, n_on = 0, n_dis = 0, n0;
   always #10 sys_clk = ~sys_clk;
   always @(posedge gate_drive_out) n_on++;
   always @(posedge sys_clk) if (ct_discharge) n_dis++;
   pwr_stage_model ps_u (.sys_clk, .gate(gate_drive_out), .ring_en, .fbk_dn, .fbk_up,
      .max_ip, .comp);
   valley_pwm_core #(.SS_CYC(512), .TICK_CYC(50), .AUTO_CYC(100)) dut_u (.sys_clk,
      .rst_n, .comp, .variant_bo, .variant_auto, .gate_drive_out, .ct_discharge,
      .setpoint, .vcc_latch_pull, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // each half released at the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      b_t = 0;
      while (!b_t) begin
         @(negedge sys_clk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         b_t = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge sys_clk);
         if (aw_t) s_axi_awvalid <= 0;
         if (w_t) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
      // let an edge pass so a following call does not re-drive in this step
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
      logic ar_t, r_t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      r_t = 0;
      while (!r_t) begin
         @(negedge sys_clk);
         ar_t = s_axi_arvalid & s_axi_arready;
         r_t = s_axi_rvalid;
         v = s_axi_rdata;
         e = s_axi_rresp;
         @(posedge sys_clk);
         if (ar_t) s_axi_arvalid <= 0;
      end
      s_axi_rready <= 0;
      @(posedge sys_clk);
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, d, r);
      chk(d & m, e);
   endtask
   task automatic step(input logic [3:0] dn, input logic [3:0] up, input int n);
      fbk_dn <= dn;
      fbk_up <= up;
      repeat (n) @(posedge sys_clk);
   endtask
   task summarize;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge sys_clk);
      fail_count++;
      summarize;
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1;
      repeat (3) @(posedge sys_clk);
      rc(`REG_CTRL, 32'h1, 32'h0);
      rd(4'h2, d, r);
      chk(r, `RESP_ERR);
      wr(`REG_IRQ_MASK, 32'h1);
      chk(br, `RESP_OK);
      wr(`REG_CTRL, 32'h1);
      step(4'h0, 4'hf, 40);
      chk(setpoint.ss_limit != 8'hff, 1);
      step(4'h0, 4'hf, 600);
      chk(setpoint.ss_limit, 8'hff);
      chk(n_on > 2, 1);
      ring_en <= 0;
      n0 = n_on;
      step(4'h0, 4'hf, 1000);
      chk(n_on - n0 > 2, 1);
      ring_en <= 1;
      step(4'h3, 4'h0, 20);
      rc(`REG_STATUS, 32'h2c, 32'h08);
      step(4'h0, 4'h0, 20);
      rc(`REG_STATUS, 32'h2c, 32'h08);
      step(4'hf, 4'h0, 20);
      rc(`REG_STATUS, 32'h2c, 32'h2c);
      chk(setpoint.fold_min, 1);
      n0 = n_dis;
      step(4'hf, 4'h0, 300);
      chk(n_dis > n0, 1);
      step(4'h0, 4'h0, 20);
      rc(`REG_STATUS, 32'h2c, 32'h2c);
      step(4'h0, 4'h1, 20);
      rc(`REG_STATUS, 32'h2c, 32'h0c);
      chk(setpoint.fbk_div4, 1);
      max_ip <= 1;
      step(4'h0, 4'h1, 300);
      rc(`REG_STATUS, 32'h40, 32'h0);
      step(4'h0, 4'h1, 200);
      rc(`REG_STATUS, 32'h40, 32'h40);
      chk({vcc_latch_pull, gate_drive_out, irq}, 3'b101);
      rc(`REG_IRQ_STAT, 32'h1, 32'h1);
      rc(`REG_IRQ_STAT, 32'h1, 32'h0);
      chk(irq, 0);
      summarize;
   end
endmodule
